// *** rtl/wic_top.sv ***
`timescale 1ns/1ps
// Functional notes
// - writing one to the idle flag bit puts the block into idle.
// - in idle only the idle timer keeps counting; nothing else runs.
// - reset or an enabled port L wakeup edge ends idle.
// - a toggle of idle timer bit twelve also ends idle.
// - each bit twelve toggle sets idle timer pending; its enable gates the interrupt.
// - timer wakeup with interrupt enabled services it first, else code resumes.
// - wakeup enable is 8-bit read/write, one bit per port L pin.
// - edge select bit set means falling edge, clear means rising edge.
// - selected edge sets wakeup pending; it stays until software clears it.
// - halt is refused while any wakeup is enabled and pending.
// - wakeup enable and edge select reset to zero.
// - every interrupt sends execution to address 00FF.
// - fixed ranking: trap highest, port L wakeup lowest, maskables fixed in between.
// - maskable taken at boundary when pending, enabled, global on, no trap service.
// - reset clears all interrupt pending, enables and the global enable.
// - enabling an already pending source raises it without a new event.
// - acknowledge waits for the next instruction start; skips happen first.
// - acknowledge clears global enable, pushes next address, loads 00FF, seven cycles.
// - return sets global enable and pops; pending work is then taken at once.
// - writing one to the halt flag bit stops all clocks and timers.
module wic_top
#(
   parameter int unsigned TC_CYCLES = wic_pkg::TC_CLK_CYCLES
)
(
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic clk_en_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   input wire logic [7:0] port_l_in,
   input wire logic [3:0] src_evt_in,
   input wire logic sw_trap_in,
   input wire logic instr_start_in,
   input wire logic instr_skip_in,
   input wire logic [14:0] next_pc_in,
   input wire logic return_from_interrupt_in,
   output logic idle_out,
   output logic halt_out,
   output logic ack_busy_out,
   output logic push_valid_out,
   output logic [14:0] push_pc_out,
   output logic pc_load_out,
   output logic [14:0] pc_load_addr_out,
   output logic pop_req_out,
   output logic [2:0] irq_src_out
);
   typedef struct packed {
      wic_pkg::wic_pwr_t pwr;
      wic_pkg::wic_ack_t ack;
      logic [7:0] pre;
      logic [15:0] t0;
      logic [2:0] ack_cnt;
      logic [7:0] wk_en;
      logic [7:0] wk_edge;
      logic [7:0] wk_pend;
      logic [5:0] irq_en;
      logic [4:0] irq_pend;
      logic global_irq_enable;
      logic trap_pend;
      logic nmi_busy;
      logic [7:0] rdata;
      logic push_valid;
      logic pc_load;
      logic pop_req;
      logic [14:0] push_pc;
      logic [14:0] pc_addr;
      logic [2:0] src;
      logic idle;
      logic halt;
      logic busy;
   } wic_state_t;

   localparam wic_state_t ST_RST = '{
      pwr: wic_pkg::WIC_RUN, ack: wic_pkg::WIC_ACK_WAIT, pre: 8'h00, t0: 16'h0000,
      ack_cnt: 3'h0, wk_en: wic_pkg::WK_EN_RST, wk_edge: wic_pkg::WK_EDGE_RST,
      wk_pend: wic_pkg::WK_PEND_RST, irq_en: wic_pkg::IRQ_EN_RST,
      irq_pend: wic_pkg::IRQ_PEND_RST, global_irq_enable: 1'b0, trap_pend: 1'b0, nmi_busy: 1'b0,
      rdata: 8'h00, push_valid: 1'b0, pc_load: 1'b0, pop_req: 1'b0,
      push_pc: 15'h0000, pc_addr: 15'h0000, src: 3'h0,
      idle: 1'b0, halt: 1'b0, busy: 1'b0};

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic rst_meta_ff;
   logic rst_sync_ff;

   always_ff @(posedge ref_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   // ----------------------------------------
   // port L edge capture
   // ----------------------------------------
   logic [7:0] edge_w;
   wic_state_t st_ff;
   wic_state_t nxt_st;

   wic_pin_edge u_pin_edge
   (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_sync_ff),
      .clk_en_in(clk_en_in),
      .pins_in(port_l_in),
      .fall_sel_in(st_ff.wk_edge),
      .edge_out(edge_w)
   );

   // ----------------------------------------
   // combinational helpers
   // ----------------------------------------
   logic tick;
   logic t0_toggle;
   logic wake_hit;
   logic halt_block;
   logic [5:0] act;
   logic [2:0] winner;
   logic take;
   logic wr_ctrl;

   // instruction-cycle tick, stopped in halt
   assign tick = (st_ff.pwr != wic_pkg::WIC_HALT) && (st_ff.pre == 8'(TC_CYCLES - 1));
   // bit twelve flips when low bits roll over
   assign t0_toggle = tick && (st_ff.t0[wic_pkg::T0_WAKE_BIT-1:0] == 12'hFFF);
   assign wake_hit = |(edge_w & st_ff.wk_en);
   assign halt_block = |(st_ff.wk_en & st_ff.wk_pend);
   // active maskables: pending and individually enabled
   assign act = {st_ff.irq_pend, halt_block} & st_ff.irq_en;
   assign wr_ctrl = reg_wr_in && (reg_addr_in == wic_pkg::ADDR_CTRL);

   // fixed rank encoder, highest index wins
   always_comb
   begin
      winner = 3'h0;
      for (int i = 0; i < wic_pkg::NUM_MASKABLE; i++)
      begin
         if (act[i])
            winner = 3'(i);
      end
   end

   // acknowledge qualification at an executed instruction start
   assign take = (st_ff.pwr == wic_pkg::WIC_RUN) && (st_ff.ack == wic_pkg::WIC_ACK_WAIT)
                 && instr_start_in && !instr_skip_in
                 && (st_ff.trap_pend || (st_ff.global_irq_enable && !st_ff.nmi_busy && (|act)));

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.push_valid = 1'b0;
      nxt_st.pc_load = 1'b0;
      nxt_st.pop_req = 1'b0;
      nxt_st.rdata = 8'h00;

      // prescaler and idle timer
      if (st_ff.pwr != wic_pkg::WIC_HALT)
      begin
         if (tick)
         begin
            nxt_st.pre = 8'h00;
            nxt_st.t0 = st_ff.t0 + 16'h0001;
         end
         else
            nxt_st.pre = st_ff.pre + 8'h01;
      end

      // register writes
      if (reg_wr_in)
      begin
         case (reg_addr_in)
            wic_pkg::ADDR_WK_EN: nxt_st.wk_en = reg_wdata_in;
            wic_pkg::ADDR_WK_EDGE: nxt_st.wk_edge = reg_wdata_in;
            wic_pkg::ADDR_IRQ_EN: nxt_st.irq_en = reg_wdata_in[5:0];
            wic_pkg::ADDR_CTRL: nxt_st.global_irq_enable = reg_wdata_in[wic_pkg::CTRL_GIE_BIT];
            default: ;
         endcase
      end

      // sticky pendings, a new event beats a clear
      nxt_st.wk_pend = ((reg_wr_in && reg_addr_in == wic_pkg::ADDR_WK_PEND) ? reg_wdata_in
                        : st_ff.wk_pend) | edge_w;
      nxt_st.irq_pend = ((reg_wr_in && reg_addr_in == wic_pkg::ADDR_IRQ_PEND)
                         ? reg_wdata_in[5:1] : st_ff.irq_pend)
                        | {src_evt_in[3], t0_toggle, src_evt_in[2:0]};
      if (sw_trap_in)
         nxt_st.trap_pend = 1'b1;

      // power modes
      case (st_ff.pwr)
         wic_pkg::WIC_RUN:
         begin
            if (wr_ctrl && reg_wdata_in[wic_pkg::CTRL_HALT_BIT])
            begin
               if (!halt_block)
                  nxt_st.pwr = wic_pkg::WIC_HALT;
            end
            else if (wr_ctrl && reg_wdata_in[wic_pkg::CTRL_IDLE_BIT])
               nxt_st.pwr = wic_pkg::WIC_IDLE;
         end
         wic_pkg::WIC_IDLE:
         begin
            if (wake_hit || t0_toggle)
               nxt_st.pwr = wic_pkg::WIC_RUN;
         end
         wic_pkg::WIC_HALT:
         begin
            if (wake_hit)
               nxt_st.pwr = wic_pkg::WIC_RUN;
         end
         default: nxt_st.pwr = wic_pkg::WIC_RUN;
      endcase

      // acknowledge sequence
      case (st_ff.ack)
         wic_pkg::WIC_ACK_WAIT:
         begin
            if (take)
            begin
               nxt_st.ack = wic_pkg::WIC_ACK_BUSY;
               nxt_st.ack_cnt = 3'h0;
               nxt_st.global_irq_enable = 1'b0;
               nxt_st.push_pc = next_pc_in;
               nxt_st.push_valid = 1'b1;
               nxt_st.pc_addr = wic_pkg::IRQ_VECTOR;
               if (st_ff.trap_pend)
               begin
                  nxt_st.trap_pend = sw_trap_in;
                  nxt_st.nmi_busy = 1'b1;
                  nxt_st.src = wic_pkg::SRC_TRAP;
               end
               else
                  nxt_st.src = winner;
            end
            else if (return_from_interrupt_in)
            begin
               nxt_st.global_irq_enable = 1'b1;
               nxt_st.nmi_busy = 1'b0;
               nxt_st.pop_req = 1'b1;
            end
         end
         wic_pkg::WIC_ACK_BUSY:
         begin
            if (tick)
            begin
               if (st_ff.ack_cnt == wic_pkg::ACK_TC_LAST)
               begin
                  nxt_st.ack = wic_pkg::WIC_ACK_WAIT;
                  nxt_st.pc_load = 1'b1;
               end
               else
                  nxt_st.ack_cnt = st_ff.ack_cnt + 3'h1;
            end
         end
         default: nxt_st.ack = wic_pkg::WIC_ACK_WAIT;
      endcase

      // mode flags registered so the outputs come from flops
      nxt_st.idle = (nxt_st.pwr == wic_pkg::WIC_IDLE);
      nxt_st.halt = (nxt_st.pwr == wic_pkg::WIC_HALT);
      nxt_st.busy = (nxt_st.ack == wic_pkg::WIC_ACK_BUSY);

      // read data, valid the cycle after the strobe
      if (reg_rd_in)
      begin
         case (reg_addr_in)
            wic_pkg::ADDR_WK_EN: nxt_st.rdata = st_ff.wk_en;
            wic_pkg::ADDR_WK_EDGE: nxt_st.rdata = st_ff.wk_edge;
            wic_pkg::ADDR_WK_PEND: nxt_st.rdata = st_ff.wk_pend;
            wic_pkg::ADDR_IRQ_EN: nxt_st.rdata = {2'b00, st_ff.irq_en};
            wic_pkg::ADDR_IRQ_PEND: nxt_st.rdata = {2'b00, st_ff.irq_pend, halt_block};
            wic_pkg::ADDR_CTRL: nxt_st.rdata = {st_ff.pwr == wic_pkg::WIC_HALT,
                                                st_ff.pwr == wic_pkg::WIC_IDLE,
                                                5'h00, st_ff.global_irq_enable};
            wic_pkg::ADDR_STATUS: nxt_st.rdata = {st_ff.trap_pend, st_ff.nmi_busy,
                                                  st_ff.ack == wic_pkg::WIC_ACK_BUSY,
                                                  2'b00, st_ff.src};
            wic_pkg::ADDR_T0_LO: nxt_st.rdata = st_ff.t0[7:0];
            wic_pkg::ADDR_T0_HI: nxt_st.rdata = st_ff.t0[15:8];
            default: nxt_st.rdata = 8'h00;
         endcase
      end
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge ref_clk_in or negedge rst_sync_ff)
   begin
      if (!rst_sync_ff)
         st_ff <= ST_RST;
      else if (clk_en_in)
         st_ff <= nxt_st;
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign reg_rdata_out = st_ff.rdata;
   assign idle_out = st_ff.idle;
   assign halt_out = st_ff.halt;
   assign ack_busy_out = st_ff.busy;
   assign push_valid_out = st_ff.push_valid;
   assign push_pc_out = st_ff.push_pc;
   assign pc_load_out = st_ff.pc_load;
   assign pc_load_addr_out = st_ff.pc_addr;
   assign pop_req_out = st_ff.pop_req;
   assign irq_src_out = st_ff.src;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [3:0] ack_ticks;

   // instruction cycles spent in one acknowledge
   always_ff @(posedge ref_clk_in or negedge rst_sync_ff)
   begin
      if (!rst_sync_ff)
         ack_ticks <= 4'h0;
      else if (clk_en_in && take)
         ack_ticks <= 4'h0;
      else if (clk_en_in && tick && st_ff.ack == wic_pkg::WIC_ACK_BUSY)
         ack_ticks <= ack_ticks + 4'h1;
   end

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_sync_ff || !clk_en_in);

   property p_idle_enter;
      st_ff.pwr == wic_pkg::WIC_RUN && wr_ctrl && reg_wdata_in == 8'h40
      |=> idle_out && !halt_out;
   endproperty
   a_idle_enter: assert property (p_idle_enter) else $error("idle not entered");

   property p_idle_no_ack;
      idle_out && tick |=> !push_valid_out && st_ff.t0 == $past(st_ff.t0) + 16'h0001;
   endproperty
   a_idle_no_ack: assert property (p_idle_no_ack) else $error("idle timer or ack wrong");

   property p_idle_t0_exit;
      idle_out && t0_toggle |=> !idle_out && st_ff.irq_pend[3];
   endproperty
   a_idle_t0_exit: assert property (p_idle_t0_exit) else $error("no timer wakeup");

   property p_wake_sticky;
      (edge_w != 8'h00) |=> ((st_ff.wk_pend & $past(edge_w)) == $past(edge_w));
   endproperty
   a_wake_sticky: assert property (p_wake_sticky) else $error("edge not latched");

   property p_halt_block;
      st_ff.pwr == wic_pkg::WIC_RUN && wr_ctrl && reg_wdata_in[7] && halt_block
      |=> !halt_out;
   endproperty
   a_halt_block: assert property (p_halt_block) else $error("halt not refused");

   property p_prio;
      take && !st_ff.trap_pend |=> (($past(act) >> (irq_src_out + 3'h1)) == 6'h00);
   endproperty
   a_prio: assert property (p_prio) else $error("lower rank chosen");

   property p_skip;
      instr_start_in && instr_skip_in |-> ##1 !push_valid_out;
   endproperty
   a_skip: assert property (p_skip) else $error("ack on skipped instruction");

   property p_ack_start;
      take |=> push_valid_out && !st_ff.global_irq_enable && ack_busy_out && push_pc_out == $past(next_pc_in);
   endproperty
   a_ack_start: assert property (p_ack_start) else $error("bad ack start");

   property p_ack_len;
      pc_load_out |-> ack_ticks == 4'h7 && pc_load_addr_out == 15'h00FF && !ack_busy_out;
   endproperty
   a_ack_len: assert property (p_ack_len) else $error("bad ack length or vector");

   property p_return_from_interrupt;
      return_from_interrupt_in && !take && !ack_busy_out |=> st_ff.global_irq_enable && pop_req_out && !st_ff.nmi_busy;
   endproperty
   a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("return did not restore");

   c_idle_wake: cover property (idle_out ##1 !idle_out);
   c_halt_refused: cover property (wr_ctrl && reg_wdata_in[7] && halt_block);
   c_ack_done: cover property (pc_load_out && !ack_busy_out);
endmodule // wic_top

// *** rtl/wic_pkg.sv ***
package wic_pkg;
   // ----------------------------------------
   // register map (8-bit data, word per index)
   // ----------------------------------------
   localparam logic [3:0] ADDR_WK_EN = 4'h0;
   localparam logic [3:0] ADDR_WK_EDGE = 4'h1;
   localparam logic [3:0] ADDR_WK_PEND = 4'h2;
   localparam logic [3:0] ADDR_IRQ_EN = 4'h3;
   localparam logic [3:0] ADDR_IRQ_PEND = 4'h4;
   localparam logic [3:0] ADDR_CTRL = 4'h5;
   localparam logic [3:0] ADDR_STATUS = 4'h6;
   localparam logic [3:0] ADDR_T0_LO = 4'h7;
   localparam logic [3:0] ADDR_T0_HI = 4'h8;

   // control register bits (port G data image)
   localparam int CTRL_GIE_BIT = 0;
   localparam int CTRL_IDLE_BIT = 6;
   localparam int CTRL_HALT_BIT = 7;

   // maskable sources, higher index wins
   localparam int IRQ_WAKE = 0;
   localparam int IRQ_SERIAL = 1;
   localparam int IRQ_T1B = 2;
   localparam int IRQ_T1A = 3;
   localparam int IRQ_T0 = 4;
   localparam int IRQ_EXT = 5;
   localparam int NUM_MASKABLE = 6;
   localparam logic [2:0] SRC_TRAP = 3'h7;

   // reset values
   localparam logic [7:0] WK_EN_RST = 8'h00;
   localparam logic [7:0] WK_EDGE_RST = 8'h00;
   localparam logic [7:0] WK_PEND_RST = 8'h00;
   localparam logic [5:0] IRQ_EN_RST = 6'h00;
   localparam logic [4:0] IRQ_PEND_RST = 5'h00;

   // timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int TC_PERIOD_PS = 1000000;
   localparam int TC_CLK_CYCLES = TC_PERIOD_PS / CLK_PERIOD_PS;
   localparam int T0_WAKE_BIT = 12;
   localparam logic [2:0] ACK_TC_LAST = 3'h6;
   localparam logic [14:0] IRQ_VECTOR = 15'h00FF;

   typedef enum logic [1:0] {WIC_RUN, WIC_IDLE, WIC_HALT} wic_pwr_t;
   typedef enum logic {WIC_ACK_WAIT, WIC_ACK_BUSY} wic_ack_t;
endpackage

// *** rtl/wic_pin_edge.sv ***
`timescale 1ns/1ps
module wic_pin_edge
(
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   input wire logic [7:0] pins_in,
   input wire logic [7:0] fall_sel_in,
   output logic [7:0] edge_out
);
   typedef struct packed {
      logic [7:0] meta;
      logic [7:0] sync;
      logic [7:0] prev;
      logic [7:0] hit;
   } wic_edge_st_t;

   wic_edge_st_t st_ff;
   wic_edge_st_t nxt_st;
   logic [7:0] hit_w;

   // ----------------------------------------
   // per pin edge compare
   // ----------------------------------------
   generate
      for (genvar i = 0; i < 8; i++)
      begin : g_pin
         // set: falling edge, clear: rising edge
         assign hit_w[i] = fall_sel_in[i] ? (st_ff.prev[i] & ~st_ff.sync[i])
                                          : (~st_ff.prev[i] & st_ff.sync[i]);
      end
   endgenerate

   // two-stage sync then history
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.meta = pins_in;
      nxt_st.sync = st_ff.meta;
      nxt_st.prev = st_ff.sync;
      nxt_st.hit = hit_w;
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         st_ff <= '0;
      else if (clk_en_in)
         st_ff <= nxt_st;
   end

   assign edge_out = st_ff.hit;
endmodule // wic_pin_edge

// *** testbench/wic_core_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// processor core stand-in: sequencer, pc, stack
// ----------------------------------------
module wic_core_model
#(
   parameter int unsigned TC = 2
)
(
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic idle_in,
   input wire logic halt_in,
   input wire logic busy_in,
   input wire logic push_valid_in,
   input wire logic [14:0] push_pc_in,
   input wire logic pc_load_in,
   input wire logic [14:0] pc_load_addr_in,
   input wire logic return_from_interrupt_req_in,
   input wire logic skip_req_in,
   output logic instr_start_out,
   output logic instr_skip_out,
   output logic [14:0] next_pc_out,
   output logic return_from_interrupt_out
);
   logic [7:0] tick_ff;
   logic [14:0] pc_ff;
   logic [14:0] stack_q[$];

   // one instruction per tick, none while stopped or acknowledging
   always @(posedge ref_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         tick_ff <= 8'h00;
         pc_ff <= 15'h0100;
         instr_start_out <= 1'b0;
         instr_skip_out <= 1'b0;
         next_pc_out <= 15'h0000;
         return_from_interrupt_out <= 1'b0;
         stack_q.delete();
      end
      else
      begin
         instr_start_out <= 1'b0;
         return_from_interrupt_out <= 1'b0;
         if (pc_load_in)
            pc_ff <= pc_load_addr_in;
         if (push_valid_in)
            stack_q.push_back(push_pc_in);
         if (return_from_interrupt_req_in)
         begin
            return_from_interrupt_out <= 1'b1;
            if (stack_q.size() > 0)
               pc_ff <= stack_q.pop_back();
         end
         else if (tick_ff >= 8'(TC - 1))
         begin
            tick_ff <= 8'h00;
            if (!idle_in && !halt_in && !busy_in)
            begin
               instr_start_out <= 1'b1;
               instr_skip_out <= skip_req_in;
               next_pc_out <= pc_ff;
               pc_ff <= pc_ff + 15'h0001;
            end
         end
         else
            tick_ff <= tick_ff + 8'h01;
      end
   end
endmodule // wic_core_model

// *** testbench/wakeup_interrupt_control_tb.sv ***
`timescale 1ns/1ps
module wakeup_interrupt_control_tb;
   localparam int unsigned TC = 2;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic trap = 1'b0;
   logic return_from_interrupt_req = 1'b0;
   logic skip_req = 1'b0;
   logic rd_seen = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [3:0] evt = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] pins = 8'h00;
   logic [7:0] rdata, en, es;
   logic start, skip, return_from_interrupt, idle, halt, busy, push_v, pc_load, pop;
   logic return_from_interrupt_seen = 1'b0;
   logic clk_en = 1'b1;
   logic [14:0] pc_note = 15'h0000;
   logic [14:0] npc, push_pc, load_addr;
   logic [2:0] src;
   logic [7:0] rd_q[$];
   logic [2:0] src_q[$];
   int err_total = 0;
   int comparisons = 0;
   int n_load = 0;
   int cyc = 0;
   int t_push = 0;

   // ----------------------------------------
   // clock, design and core stand-in
   // ----------------------------------------
   always #2.5 clk = ~clk;

   wic_top #(.TC_CYCLES(TC)) uut (.ref_clk_in(clk), .nrst_in(nrst), .clk_en_in(clk_en),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .port_l_in(pins), .src_evt_in(evt), .sw_trap_in(trap),
      .instr_start_in(start), .instr_skip_in(skip), .next_pc_in(npc), .return_from_interrupt_in(return_from_interrupt),
      .idle_out(idle), .halt_out(halt), .ack_busy_out(busy), .push_valid_out(push_v),
      .push_pc_out(push_pc), .pc_load_out(pc_load), .pc_load_addr_out(load_addr),
      .pop_req_out(pop), .irq_src_out(src));

   wic_core_model #(.TC(TC)) core (.ref_clk_in(clk), .nrst_in(nrst), .idle_in(idle),
      .halt_in(halt), .busy_in(busy), .push_valid_in(push_v), .push_pc_in(push_pc),
      .pc_load_in(pc_load), .pc_load_addr_in(load_addr), .return_from_interrupt_req_in(return_from_interrupt_req),
      .skip_req_in(skip_req), .instr_start_out(start), .instr_skip_out(skip),
      .next_pc_out(npc), .return_from_interrupt_out(return_from_interrupt));

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic end_of_test();
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // read strobe, expected data noted for the watcher
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      rd_q.push_back(d);
      @(posedge clk);
      rd <= 1'b0;
   endtask

   task automatic pulse_return_from_interrupt();
      @(posedge clk);
      return_from_interrupt_req <= 1'b1;
      @(posedge clk);
      return_from_interrupt_req <= 1'b0;
   endtask

   task automatic wait_ack();
      int n;
      n = n_load;
      for (int k = 0; k < 200 && n_load == n; k++)
         @(negedge clk);
      if (n_load == n)
      begin
         err_total++;
         end_of_test();
      end
   endtask

   // ----------------------------------------
   // watcher: pops notes as results appear
   // ----------------------------------------
   always @(posedge clk)
   begin
      cyc++;
      if (rd_seen)
         check(16'(rdata), 16'(rd_q.pop_front()));
      rd_seen = rd;
      if (return_from_interrupt_seen)
         check(16'(pop), 16'h0001);
      return_from_interrupt_seen = return_from_interrupt;
      if (push_v === 1'b1)
      begin
         check(16'(src), 16'(src_q.pop_front()));
         check(16'(push_pc), 16'(pc_note));
         t_push = cyc;
      end
      // address of the last executed instruction start
      if (start === 1'b1 && skip === 1'b0)
         pc_note = npc;
      if (pc_load === 1'b1)
      begin
         check(16'(load_addr), 16'h00FF);
         check(16'(cyc - t_push >= 6 * TC + 1 && cyc - t_push <= 7 * TC), 16'h0001);
         n_load++;
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      void'($urandom(32'h3BE16F4F));
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      repeat (5) @(posedge clk);
      for (int i = 0; i < 7; i++)
         rd_reg(4'(i), 8'h00);
      rd_reg(4'hF, 8'h00);
      en = 8'($urandom());
      es = 8'($urandom());
      wr_reg(wic_pkg::ADDR_WK_EDGE, es);
      wr_reg(wic_pkg::ADDR_WK_PEND, 8'h00);
      wr_reg(wic_pkg::ADDR_WK_EN, en);
      rd_reg(wic_pkg::ADDR_WK_EN, en);
      rd_reg(wic_pkg::ADDR_WK_EDGE, es);
      pins <= 8'hFF;
      repeat (8) @(posedge clk);
      rd_reg(wic_pkg::ADDR_WK_PEND, ~es);
      rd_reg(wic_pkg::ADDR_IRQ_PEND, {7'h00, |(en & ~es)});
      pins <= 8'h00;
      repeat (8) @(posedge clk);
      rd_reg(wic_pkg::ADDR_WK_PEND, 8'hFF);
      // halt refused while enabled wake pending, then woken by pin 0
      wr_reg(wic_pkg::ADDR_WK_EN, 8'h00);
      wr_reg(wic_pkg::ADDR_WK_EDGE, 8'h00);
      wr_reg(wic_pkg::ADDR_WK_EN, 8'h01);
      wr_reg(wic_pkg::ADDR_CTRL, 8'h80);
      repeat (3) @(negedge clk);
      check(16'(halt), 16'h0000);
      wr_reg(wic_pkg::ADDR_WK_PEND, 8'h00);
      wr_reg(wic_pkg::ADDR_CTRL, 8'h80);
      repeat (2) @(negedge clk);
      check(16'(halt), 16'h0001);
      @(posedge clk);
      pins <= 8'h01;
      for (int k = 0; k < 20 && halt === 1'b1; k++)
         @(negedge clk);
      check(16'(halt), 16'h0000);
      if (halt !== 1'b0)
         end_of_test();
      repeat (2 * TC) @(posedge clk); // two no-op slots after wakeup
      rd_reg(wic_pkg::ADDR_WK_PEND, 8'h01);
      // idle ended by the idle timer
      wr_reg(wic_pkg::ADDR_WK_EN, 8'h00);
      wr_reg(wic_pkg::ADDR_CTRL, 8'h40);
      repeat (2) @(negedge clk);
      check(16'(idle), 16'h0001);
      for (int k = 0; k < 4096 * TC + 100 && idle; k++)
         @(negedge clk);
      check(16'(idle), 16'h0000);
      if (idle !== 1'b0)
         end_of_test();
      rd_reg(wic_pkg::ADDR_IRQ_PEND, 8'h10);
      // maskable sources, ranking and return
      @(posedge clk);
      evt <= 4'hF;
      @(posedge clk);
      evt <= 4'h0;
      rd_reg(wic_pkg::ADDR_IRQ_PEND, 8'h3E);
      wr_reg(wic_pkg::ADDR_IRQ_EN, 8'h3F);
      repeat (10) @(negedge clk);
      check(16'(busy), 16'h0000);
      src_q.push_back(3'h5);
      wr_reg(wic_pkg::ADDR_CTRL, 8'h01);
      wait_ack();
      rd_reg(wic_pkg::ADDR_CTRL, 8'h00);
      for (int k = 5; k >= 1; k--)
      begin
         wr_reg(wic_pkg::ADDR_IRQ_PEND, 8'((16'h0002 << k) - 16'h0002));
         src_q.push_back(3'(k));
         skip_req <= (k == 3);
         pulse_return_from_interrupt();
         if (k == 3)
         begin
            repeat (8) @(negedge clk);
            check(16'(busy), 16'h0000);
            @(posedge clk);
            skip_req <= 1'b0;
         end
         wait_ack();
      end
      // trap preempts, blocks maskables until its return
      @(posedge clk);
      trap <= 1'b1;
      @(posedge clk);
      trap <= 1'b0;
      src_q.push_back(3'h7);
      wait_ack();
      wr_reg(wic_pkg::ADDR_CTRL, 8'h01);
      repeat (10) @(negedge clk);
      check(16'(busy), 16'h0000);
      src_q.push_back(3'h1);
      pulse_return_from_interrupt();
      wait_ack();
      // a write while the clock enable is low is lost
      @(posedge clk);
      clk_en <= 1'b0;
      wr_reg(wic_pkg::ADDR_WK_EN, 8'hFF);
      clk_en <= 1'b1;
      rd_reg(wic_pkg::ADDR_WK_EN, 8'h00);
      repeat (20) @(posedge clk);
      end_of_test();
   end
endmodule // wakeup_interrupt_control_tb
